//--- logic/adcs_sequencer.sv
`timescale 1ns/10ps
`include "adcs_params.svh"
// Summary of operation
// - Conversion takes nine and a half periods
// - Clock select picks divide or RC
// - Analog-configured pins read back as zero
// - Output-driven channel converts its driven level
// - Digital-input channel still converts normally
// - Clearing go aborts, result untouched
// - Abort waits two periods, then acquires (at once if still in the RC start delay)
// - Completion clears go, loads result, flags
// - RC clock delays start one instruction
// - RC conversion runs in sleep, wakes
// - Sleep completion without irq powers down
// - Sleep with oscillator clock aborts, powers down
// - Bits after fast switch are invalid
// - Acquisition same regardless of resolution
// - Go starts conversion, reads one meanwhile
// - Channel select routes one of five
// - Capacitor reconnected two periods after finish
// - Port config sets analog pins, reference
module adcs_sequencer (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESET_N,
    // Software control side
    input wire logic CTRL_WE,
    input wire adcs_pkg::adcs_ctrl_s CTRL_WDATA,
    output adcs_pkg::adcs_ctrl_s CTRL_RDATA,
    input wire logic [2:0] PORT_CONFIG_SELECT,
    input wire logic RESULT_WE,
    input wire logic [7:0] RESULT_WDATA,
    output logic [7:0] CONVERSION_RESULT,
    input wire logic CONVERSION_IRQ_ENABLE,
    input wire logic DONE_FLAG_CLR,
    output logic CONVERSION_DONE_FLAG,
    // Power management
    input wire logic SLEEP,
    output logic WAKEUP,
    // RC oscillator half-period tick
    input wire logic RC_TICK,
    // Port A digital side
    input wire logic [5:0] PORT_A_PIN_LEVEL,
    input wire logic [5:0] PORT_A_DIRECTION,
    output logic [5:0] PORT_A_READ,
    output logic VREF_EXTERNAL,
    // Analog front end
    output logic [2:0] CHANNEL_SEL,
    output logic SAMPLE_CONNECT,
    output logic ANALOG_POWER,
    output logic [7:0] DAC_CODE,
    input wire logic CMP_HIGH
);

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Half bit-conversion period in oscillator cycles
    function automatic logic [4:0] half_len(input logic [1:0] sel);
        unique case (sel)
            `ADCS_SEL_DIV2: half_len = `ADCS_HALF_DIV2;
            `ADCS_SEL_DIV8: half_len = `ADCS_HALF_DIV8;
            default: half_len = `ADCS_HALF_DIV32;
        endcase
    endfunction

    // Analog pin mask over RA5..RA0 (RA4 is never analog)
    function automatic logic [5:0] analog_mask(input logic [2:0] cfg);
        unique case (cfg)
            `ADCS_CFG_ALL_A, `ADCS_CFG_ALL_A2: analog_mask = 6'h2F;
            `ADCS_CFG_A_VREF, `ADCS_CFG_A_VREF2: analog_mask = 6'h2F;
            `ADCS_CFG_THREE_A: analog_mask = 6'h0B;
            default: analog_mask = 6'h00;
        endcase
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    localparam logic [2:0] INSTR_CLKS = 3'(`ADCS_INSTR_CLKS);

    adcs_pkg::adcs_state_e state_q, state_d;
    adcs_pkg::adcs_ctrl_s ctrl_q, ctrl_d;
    logic [4:0] div_q, div_d;
    logic [4:0] half_q, half_d;
    logic [2:0] dly_q, dly_d;
    logic [7:0] sar_q, sar_d;
    logic [7:0] mask_q, mask_d;
    logic [7:0] result_q, result_d;
    logic done_q, done_d;
    logic wake_q, wake_d;
    logic pdown_q, pdown_d;
    logic tick;
    logic rc_sel;
    logic powered;

    // Step source; switching clocks mid-run only changes later bits
    assign rc_sel = (ctrl_q.conv_clock_select == `ADCS_SEL_RC);
    assign tick = rc_sel ? RC_TICK
                : (div_q == half_len(ctrl_q.conv_clock_select) - 5'h01);
    assign powered = ctrl_q.converter_on & ~pdown_q;

    // ************************************************************
    // Next-state logic
    // ************************************************************

    // Sequencer, SAR and software-visible bits
    always_comb begin
        state_d = state_q;
        ctrl_d = ctrl_q;
        div_d = tick ? 5'h00 : div_q + 5'h01;
        half_d = half_q;
        dly_d = dly_q;
        sar_d = sar_q;
        mask_d = mask_q;
        result_d = result_q;
        done_d = done_q;
        wake_d = 1'b0;
        pdown_d = pdown_q;
        if (rc_sel || state_q != adcs_pkg::ST_CONV) begin
            if (state_q != adcs_pkg::ST_HOLD) begin
                div_d = 5'h00;
            end
        end
        if (state_q == adcs_pkg::ST_HOLD && rc_sel) begin
            div_d = 5'h00;
        end
        // Software writes first; hardware events below override it, save a same-cycle go set at completion
        if (CTRL_WE) begin
            ctrl_d = CTRL_WDATA;
            pdown_d = 1'b0;
            if (!CTRL_WDATA.converter_on) begin
                ctrl_d.go = 1'b0;
            end
        end
        if (RESULT_WE) begin
            result_d = RESULT_WDATA;
        end
        if (DONE_FLAG_CLR) begin
            done_d = 1'b0;
        end
        unique case (state_q)
            adcs_pkg::ST_OFF: begin
                if (powered) begin
                    state_d = adcs_pkg::ST_ACQ;
                end
            end
            adcs_pkg::ST_ACQ: begin
                // Acquisition has no resolution-dependent length
                if (ctrl_q.go && powered) begin
                    if (rc_sel) begin
                        state_d = adcs_pkg::ST_DELAY;
                        dly_d = 3'h0;
                    end else begin
                        state_d = adcs_pkg::ST_CONV;
                    end
                    half_d = 5'h00;
                    sar_d = `ADCS_SAR_MSB;
                    mask_d = `ADCS_SAR_MSB;
                end
            end
            adcs_pkg::ST_DELAY: begin
                dly_d = dly_q + 3'h1;
                if (dly_q == INSTR_CLKS - 3'h1) begin
                    state_d = adcs_pkg::ST_CONV;
                end
                if (!ctrl_q.go) begin
                    state_d = adcs_pkg::ST_ACQ;
                end
            end
            adcs_pkg::ST_CONV: begin
                if (tick) begin
                    half_d = half_q + 5'h01;
                    // Bit decision at the end of each bit period
                    if (half_q >= `ADCS_SAMPLE_HALVES + 5'h01
                        && !half_q[0]) begin
                        sar_d = CMP_HIGH ? sar_q : (sar_q & ~mask_q);
                        sar_d = sar_d | (mask_q >> 1);
                        mask_d = mask_q >> 1;
                    end
                    if (half_q == `ADCS_CONV_HALVES - 5'h01) begin
                        result_d = CMP_HIGH ? sar_q
                                 : (sar_q & ~mask_q);
                        ctrl_d.go = 1'b0;
                        if (CTRL_WE && CTRL_WDATA.go) begin
                            ctrl_d.go = CTRL_WDATA.converter_on;
                        end
                        done_d = 1'b1;
                        half_d = 5'h00;
                        state_d = adcs_pkg::ST_HOLD;
                        if (SLEEP) begin
                            wake_d = CONVERSION_IRQ_ENABLE;
                            pdown_d = ~CONVERSION_IRQ_ENABLE;
                        end
                    end
                end
                // Abort leaves the result alone and still holds off
                if (!ctrl_q.go) begin
                    half_d = 5'h00;
                    state_d = adcs_pkg::ST_HOLD;
                end
            end
            adcs_pkg::ST_HOLD: begin
                if (tick) begin
                    half_d = half_q + 5'h01;
                    if (half_q == `ADCS_HOLD_HALVES - 5'h01) begin
                        state_d = adcs_pkg::ST_ACQ;
                    end
                end
            end
            default: state_d = adcs_pkg::ST_OFF;
        endcase
        // Sleep on an oscillator clock kills the run, bit stays set
        if (SLEEP && !rc_sel && state_q != adcs_pkg::ST_OFF) begin
            pdown_d = 1'b1;
            ctrl_d.go = 1'b0;
        end
        if (!powered || pdown_d) begin
            state_d = adcs_pkg::ST_OFF;
            if (state_q == adcs_pkg::ST_CONV && ctrl_d.go) begin
                ctrl_d.go = 1'b0;
            end
        end
        // Hardware set beats a same-cycle software clear
        if (done_q && !DONE_FLAG_CLR) begin
            done_d = 1'b1;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************

    // All state resets synchronously
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            state_q <= adcs_pkg::ST_OFF;
            ctrl_q <= '0;
            div_q <= 5'h00;
            half_q <= 5'h00;
            dly_q <= 3'h0;
            sar_q <= 8'h00;
            mask_q <= 8'h00;
            result_q <= `ADCS_RESULT_RST;
            done_q <= 1'b0;
            wake_q <= 1'b0;
            pdown_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ctrl_q <= ctrl_d;
            div_q <= div_d;
            half_q <= half_d;
            dly_q <= dly_d;
            sar_q <= sar_d;
            mask_q <= mask_d;
            result_q <= result_d;
            done_q <= done_d;
            wake_q <= wake_d;
            pdown_q <= pdown_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Channel routing ignores pin direction and digital config
    assign CHANNEL_SEL = ctrl_q.input_channel_select;
    assign SAMPLE_CONNECT = (state_q == adcs_pkg::ST_ACQ)
                          || (state_q == adcs_pkg::ST_DELAY)
                          || (state_q == adcs_pkg::ST_CONV
                              && half_q < `ADCS_SAMPLE_HALVES - 5'h02);
    assign ANALOG_POWER = powered;
    assign DAC_CODE = sar_q;
    assign CTRL_RDATA = ctrl_q;
    assign CONVERSION_RESULT = result_q;
    assign CONVERSION_DONE_FLAG = done_q;
    assign WAKEUP = wake_q;

    // Pins configured analog read as low
    assign PORT_A_READ = PORT_A_PIN_LEVEL
                       & ~analog_mask(PORT_CONFIG_SELECT);
    assign VREF_EXTERNAL = (PORT_CONFIG_SELECT == `ADCS_CFG_A_VREF)
                         || (PORT_CONFIG_SELECT == `ADCS_CFG_A_VREF2);

endmodule

//--- logic/adcs_params.svh
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH

// ****************************************************************
// Clock select codes and half-period divider lengths (MCLK cycles)
// ****************************************************************
`define ADCS_SEL_DIV2 2'h0
`define ADCS_SEL_DIV8 2'h1
`define ADCS_SEL_DIV32 2'h2
`define ADCS_SEL_RC 2'h3
`define ADCS_HALF_DIV2 5'h01
`define ADCS_HALF_DIV8 5'h04
`define ADCS_HALF_DIV32 5'h10

// ****************************************************************
// Conversion timing in half bit-conversion periods
// ****************************************************************
`define ADCS_CONV_HALVES 5'h13
`define ADCS_SAMPLE_HALVES 5'h03
`define ADCS_HOLD_HALVES 5'h04

// ****************************************************************
// Start delay for the RC clock: one instruction cycle
// ****************************************************************
`define ADCS_CLK_PERIOD_NS 8
`define ADCS_INSTR_TIME_NS 32
`define ADCS_INSTR_CLKS \
    ((`ADCS_INSTR_TIME_NS + `ADCS_CLK_PERIOD_NS - 1) / `ADCS_CLK_PERIOD_NS)

// ****************************************************************
// Reset values, SAR start code and port configuration codes
// ****************************************************************
`define ADCS_RESULT_RST 8'h00
`define ADCS_SAR_MSB 8'h80
`define ADCS_CFG_ALL_A 3'h0
`define ADCS_CFG_A_VREF 3'h1
`define ADCS_CFG_ALL_A2 3'h2
`define ADCS_CFG_A_VREF2 3'h3
`define ADCS_CFG_THREE_A 3'h4

`endif

//--- logic/adcs_pkg.sv
package adcs_pkg;

    // Software-visible converter control fields
    typedef struct packed {
        logic [1:0] conv_clock_select;
        logic [2:0] input_channel_select;
        logic go;
        logic converter_on;
    } adcs_ctrl_s;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_OFF,
        ST_ACQ,
        ST_DELAY,
        ST_CONV,
        ST_HOLD
    } adcs_state_e;

endpackage

//--- verif/adcs_properties.sv
`timescale 1ns/10ps
// ****************************************
// Port-level checks of the sequencer
// ****************************************
module adcs_properties (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESET_N,
    // Inputs seen
    input wire logic RESULT_WE,
    input wire logic DONE_FLAG_CLR,
    input wire logic SLEEP,
    input wire logic CONVERSION_IRQ_ENABLE,
    input wire logic [2:0] PORT_CONFIG_SELECT,
    input wire logic [5:0] PORT_A_PIN_LEVEL,
    // Outputs judged
    input wire adcs_pkg::adcs_ctrl_s CTRL_RDATA,
    input wire logic [7:0] CONVERSION_RESULT,
    input wire logic CONVERSION_DONE_FLAG,
    input wire logic WAKEUP,
    input wire logic [5:0] PORT_A_READ,
    input wire logic SAMPLE_CONNECT,
    input wire logic ANALOG_POWER,
    input wire logic [7:0] DAC_CODE
);
    // Short names for the control fields
    wire logic go = CTRL_RDATA.go;
    wire logic on = CTRL_RDATA.converter_on;
    wire logic [1:0] sel = CTRL_RDATA.conv_clock_select;

    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    conv_length_a: assert property (
        $rose(go) && sel == 2'h0 |-> ##19 go ##1 !go
    ) else $error("conversion length wrong");
    sar_msb_a: assert property (
        $rose(go) && sel == 2'h0 |-> ##1 DAC_CODE == 8'h80
    ) else $error("first trial code wrong");
    done_load_a: assert property (
        $rose(CONVERSION_DONE_FLAG) |-> $fell(go)
    ) else $error("done set without go clearing");
    done_sticky_a: assert property (
        CONVERSION_DONE_FLAG && !DONE_FLAG_CLR |=> CONVERSION_DONE_FLAG
    ) else $error("done flag lost");
    result_keep_a: assert property (
        $changed(CONVERSION_RESULT) |->
            $past(RESULT_WE) || ($fell(go) && CONVERSION_DONE_FLAG)
    ) else $error("result changed without cause");
    hold_off_a: assert property (
        $fell(go) |-> !SAMPLE_CONNECT [*4]
    ) else $error("sampling resumed too early");
    wake_pulse_a: assert property (
        WAKEUP |-> SLEEP && CONVERSION_IRQ_ENABLE ##1 !WAKEUP
    ) else $error("bad wake pulse");
    osc_sleep_a: assert property (
        $rose(SLEEP) && sel != 2'h3 && on |-> ##2 !go && !ANALOG_POWER && on
    ) else $error("sleep did not abort");
    rc_sleep_a: assert property (
        $fell(go) && SLEEP && sel == 2'h3 && !CONVERSION_IRQ_ENABLE
            |-> ##[0:2] !ANALOG_POWER && on
    ) else $error("no power down after sleep conversion");
    off_idle_a: assert property (
        !on |-> !go && !ANALOG_POWER
    ) else $error("busy while off");
    read_mask_a: assert property (
        PORT_CONFIG_SELECT == 3'h0 |-> (PORT_A_READ & 6'h2F) == 6'h00
            && PORT_A_READ[4] == PORT_A_PIN_LEVEL[4]
    ) else $error("analog pin read not zero");
endmodule

//--- verif/adcs_analog_model.sv
`timescale 1ns/10ps
// ****************************************
// Analog side: channel mux and comparator
// ****************************************
module adcs_analog_model (
    // From the sequencer
    input wire logic [2:0] chan,
    input wire logic [7:0] dac,
    // Pin state and source levels
    input wire logic [5:0] pins,
    input wire logic [5:0] dirs,
    input wire logic [39:0] ain,
    // Comparator decision
    output logic cmp_high
);
    logic [2:0] pin;
    logic [7:0] lvl;

    // Unused codes give ground, so a stray select shows as zero
    always_comb begin
        pin = (chan == 3'h4) ? 3'h5 : chan;
        lvl = 8'h00;
        if (chan <= 3'h4) begin
            lvl = ain[{chan, 3'h0} +: 8];
            if (!dirs[pin]) begin
                lvl = pins[pin] ? 8'hFF : 8'h00;
            end
        end
        cmp_high = (lvl >= dac);
    end
endmodule

//--- verif/tb_adcs_sequencer.sv
`timescale 1ns/10ps
module tb_adcs_sequencer;
    // ****************************************
    // Bench signals, device and analog side
    // ****************************************
    logic mclk, reset_n, we, rwe, irq, clr, slp, done, wake, vref;
    logic conn, apwr, cmp, rct;
    logic [2:0] cfg, ch_o;
    logic [5:0] pins, dirs, prd;
    logic [7:0] rwd, res, dac;
    logic [39:0] ain;
    adcs_pkg::adcs_ctrl_s wd, rd;
    int num_errors, num_checks, cyc, go_n;

    // RC tick high unless a scenario stalls it: one half period a clock
    adcs_sequencer dut_u (
        .MCLK(mclk), .RESET_N(reset_n), .CTRL_WE(we), .CTRL_WDATA(wd),
        .CTRL_RDATA(rd), .PORT_CONFIG_SELECT(cfg), .RESULT_WE(rwe),
        .RESULT_WDATA(rwd), .CONVERSION_RESULT(res),
        .CONVERSION_IRQ_ENABLE(irq), .DONE_FLAG_CLR(clr),
        .CONVERSION_DONE_FLAG(done), .SLEEP(slp), .WAKEUP(wake),
        .RC_TICK(rct), .PORT_A_PIN_LEVEL(pins), .PORT_A_DIRECTION(dirs),
        .PORT_A_READ(prd), .VREF_EXTERNAL(vref), .CHANNEL_SEL(ch_o),
        .SAMPLE_CONNECT(conn), .ANALOG_POWER(apwr), .DAC_CODE(dac),
        .CMP_HIGH(cmp));
    adcs_analog_model afe_u (.chan(ch_o), .dac(dac), .pins(pins),
        .dirs(dirs), .ain(ain), .cmp_high(cmp));

    // Clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Hang limit; the whole run needs under 6000 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Wide compare for cycle counts
    task automatic chk_n(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Inputs always move 1 ns after an edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [1:0] s, input logic [2:0] c,
                      input logic g);
        tick(1);
        we = 1'b1;
        wd = {s, c, g, 1'b1};
        tick(1);
        we = 1'b0;
    endtask
    // Counts the clocks for which go still reads one
    task automatic wait_go;
        go_n = 0;
        while (rd.go === 1'b1 && go_n < 2000) begin
            tick(1);
            go_n++;
        end
    endtask
    task automatic conv(input logic [1:0] s, input logic [2:0] c,
                        input logic [7:0] e, input logic [15:0] n);
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        // Start from acquisition so the run length is exact
        while (conn !== 1'b1) begin
            tick(1);
        end
        wr(s, c, 1'b1);
        wait_go();
        chk_n(16'(go_n), n);
        tick(1);
        chk(res, e);
        chk({7'h0, done}, 8'h01);
    endtask

    task automatic t_modes;
        logic [15:0] n;
        wr(2'h0, 3'h0, 1'b0);
        for (int s = 0; s < 4; s++) begin
            // One start clock plus 19 halves of 1, 4 or 16; RC adds 4
            case (2'(s))
                2'h0: n = 16'h0014;
                2'h1: n = 16'h004D;
                2'h2: n = 16'h0131;
                default: n = 16'h0018;
            endcase
            for (int c = 0; c < 5; c++) begin
                conv(2'(s), 3'(c), ain[c*8 +: 8], n);
            end
        end
    endtask
    task automatic t_port(input logic [2:0] c, input logic [5:0] e,
                          input logic v);
        cfg = c;
        tick(1);
        chk({2'h0, prd}, {2'h0, e});
        chk({7'h0, vref}, {7'h0, v});
    endtask
    task automatic t_dir;
        cfg = 3'h7;
        conv(2'h0, 3'h1, ain[15:8], 16'h0014);
        dirs = 6'h3D;
        conv(2'h0, 3'h1, 8'hFF, 16'h0014);
        pins = 6'h3D;
        conv(2'h0, 3'h1, 8'h00, 16'h0014);
        dirs = 6'h3F;
        pins = 6'h3F;
    endtask
    // Abort in mid-conversion after a software result write
    task automatic t_abort;
        rwd = 8'h5A;
        rwe = 1'b1;
        tick(1);
        rwe = 1'b0;
        wr(2'h1, 3'h0, 1'b1);
        tick(20);
        wr(2'h1, 3'h0, 1'b0);
        tick(6);
        chk(res, 8'h5A);
        chk({7'h0, conn}, 8'h00);
        tick(30);
        chk({7'h0, conn}, 8'h01);
    endtask
    // RC here ticks every clock, so its bit period equals that of the divide-by-2 select
    task automatic t_rc;
        wr(2'h3, 3'h2, 1'b1);
        tick(21);
        chk({7'h0, rd.go}, 8'h01);
        wait_go();
        tick(1);
        chk(res, ain[23:16]);
        // A stalled RC source must stall the sequencer with it
        rct = 1'b0;
        wr(2'h3, 3'h2, 1'b1);
        tick(40);
        chk({7'h0, rd.go}, 8'h01);
        rct = 1'b1;
        wait_go();
    endtask
    // Divider switch mid-run; the ideal comparator keeps every bit good
    task automatic t_switch;
        while (conn !== 1'b1) begin
            tick(1);
        end
        wr(2'h1, 3'h3, 1'b1);
        tick(20);
        wr(2'h0, 3'h3, 1'b1);
        wait_go();
        tick(1);
        chk(res, ain[31:24]);
    endtask
    task automatic t_sleep;
        int n;
        n = 0;
        irq = 1'b1;
        wr(2'h3, 3'h0, 1'b1);
        slp = 1'b1;
        while (wake !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk({7'h0, wake}, 8'h01);
        chk(res, ain[7:0]);
        tick(1);
        slp = 1'b0;
        irq = 1'b0;
        wr(2'h3, 3'h4, 1'b1);
        slp = 1'b1;
        wait_go();
        tick(3);
        chk({6'h0, apwr, rd.converter_on}, 8'h01);
        slp = 1'b0;
        wr(2'h1, 3'h0, 1'b1);
        tick(10);
        slp = 1'b1;
        tick(3);
        chk({6'h0, apwr, rd.go}, 8'h00);
        chk({7'h0, rd.converter_on}, 8'h01);
        slp = 1'b0;
        wr(2'h0, 3'h0, 1'b0);
        chk({7'h0, apwr}, 8'h01);
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        reset_n = 1'b0;
        we = 1'b0;
        wd = '0;
        rwe = 1'b0;
        rwd = 8'h00;
        irq = 1'b0;
        clr = 1'b0;
        slp = 1'b0;
        cfg = 3'h0;
        pins = 6'h3F;
        dirs = 6'h3F;
        ain = 40'h3CC301FEA5;
        rct = 1'b1;
        tick(6);
        reset_n = 1'b1;
        chk({1'b0, rd}, 8'h00);
        t_modes();
        t_port(3'h0, 6'h10, 1'b0);
        t_port(3'h1, 6'h10, 1'b1);
        t_port(3'h4, 6'h34, 1'b0);
        t_port(3'h7, 6'h3F, 1'b0);
        t_dir();
        t_abort();
        t_rc();
        t_switch();
        t_sleep();
        finish_test();
    end
endmodule

bind adcs_sequencer adcs_properties chk_u (.MCLK(MCLK), .RESET_N(RESET_N),
    .RESULT_WE(RESULT_WE), .DONE_FLAG_CLR(DONE_FLAG_CLR), .SLEEP(SLEEP),
    .CONVERSION_IRQ_ENABLE(CONVERSION_IRQ_ENABLE), .WAKEUP(WAKEUP),
    .PORT_CONFIG_SELECT(PORT_CONFIG_SELECT), .CTRL_RDATA(CTRL_RDATA),
    .PORT_A_PIN_LEVEL(PORT_A_PIN_LEVEL), .DAC_CODE(DAC_CODE),
    .CONVERSION_RESULT(CONVERSION_RESULT), .PORT_A_READ(PORT_A_READ),
    .CONVERSION_DONE_FLAG(CONVERSION_DONE_FLAG),
    .SAMPLE_CONNECT(SAMPLE_CONNECT), .ANALOG_POWER(ANALOG_POWER));
